// File: core/driver_spi_frame_interface.sv
// Slave side of the 32-bit command and response frame link
`timescale 1ns/10ps
module driver_spi_frame_interface #(
   parameter int          CHAN_COUNT = 12,
   parameter logic [19:0] IDENT_CODE = 20'h0a5c3 // Arbitrary value
) (
   input  wire logic                  clock,
   input  wire logic                  arst_n,
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [7:0]            paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   input  wire logic                  sclk,
   input  wire logic                  csN,
   input  wire logic                  mosi,
   output logic                       misoOut,
   output logic                       misoOe,
   input  wire logic [7:0]            diagSet,
   input  wire logic [CHAN_COUNT-1:0] chanFault,
   output logic      [CHAN_COUNT-1:0] chanState,
   output logic                       cmdValid,
   output logic                       cmdWrite,
   output logic      [6:0]            cmdAddr,
   output logic      [19:0]           cmdData
);
   localparam int DW = spi_frame_pkg::DATA_W;
   localparam int FB = spi_frame_pkg::FRAME_BITS;

   if (CHAN_COUNT < 1 || CHAN_COUNT > DW) begin : g_chk
      $error("CHAN_COUNT must lie between 1 and the data width");
   end

   link_sync_if lnk ();

   assign lnk.sclkRaw = sclk;
   assign lnk.csNRaw  = csN;
   assign lnk.mosiRaw = mosi;

   link_sync u_sync (
      .clock  (clock),
      .arst_n (arst_n),
      .lnk    (lnk)
   );

   logic [1:0]            ctrl_reg;
   logic                  sclkPrev_reg;
   logic                  csPrev_reg;
   logic [31:0]           rxShift_reg;
   logic [31:0]           txShift_reg;
   logic [5:0]            bitCnt_reg;
   logic                  firstShift_reg;
   logic [2:0]            errPend_reg;
   logic [2:0]            lastErr_reg;
   logic [7:0]            frameCnt_reg;
   logic [7:0]            diag_reg;
   logic [7:0]            diag_next;
   logic [19:0]           respData_reg;
   logic [19:0]           respNext_reg;
   logic [27:0]           lastCmd_reg;
   logic [CHAN_COUNT-1:0] chanState_reg;
   logic                  cmdValid_reg;
   logic                  cmdWrite_reg;
   logic [6:0]            cmdAddr_reg;
   logic [19:0]           cmdData_reg;
   logic [31:0]           prdata_reg;
   logic                  misoOe_reg;

   logic        cpol;
   logic        cpha;
   logic        csActive;
   logic        csFall;
   logic        csRise;
   logic        sclkRise;
   logic        sclkFall;
   logic        leadEdge;
   logic        trailEdge;
   logic        sampleEdge;
   logic        shiftEdge;
   logic [2:0]  rxCrc;
   logic [2:0]  txCrc;
   logic        crcOk;
   logic        shortErr;
   logic        longErr;
   logic        crcErr;
   logic        exec;
   logic        rxWrite;
   logic [6:0]  rxAddr;
   logic [19:0] rxData;
   logic        isReadOnly;
   logic        effWrite;
   logic [5:0]  excpBits;
   logic [28:0] respBody;
   logic [31:0] rdMux;
   logic        hit;
   logic        apbWr;

   assign cpol = ctrl_reg[spi_frame_pkg::CTRL_CPOL];
   assign cpha = ctrl_reg[spi_frame_pkg::CTRL_CPHA];

   // Edges are found on the synchronised copies only
   assign csActive  = !lnk.csNS;
   assign csFall    = !lnk.csNS && csPrev_reg;
   assign csRise    = lnk.csNS && !csPrev_reg;
   assign sclkRise  = lnk.sclkS && !sclkPrev_reg;
   assign sclkFall  = !lnk.sclkS && sclkPrev_reg;
   assign leadEdge  = cpol ? sclkFall : sclkRise; // R18
   assign trailEdge = cpol ? sclkRise : sclkFall; // R18
   assign sampleEdge = csActive && (cpha ? trailEdge : leadEdge); // R19
   assign shiftEdge  = csActive && (cpha ? leadEdge : trailEdge); // R19

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         sclkPrev_reg <= 1'b0;
         csPrev_reg   <= 1'b1;
      end else begin
         sclkPrev_reg <= lnk.sclkS;
         csPrev_reg   <= lnk.csNS;
      end
   end

   // Receive shifter and bit count; count saturates past a full frame
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rxShift_reg <= 32'h0;
         bitCnt_reg  <= 6'h0;
      end else if (csFall) begin
         bitCnt_reg <= 6'h0;
      end else if (sampleEdge) begin
         rxShift_reg <= {rxShift_reg[30:0], lnk.mosiS}; // R16 R17
         if (bitCnt_reg <= 6'h20) begin
            bitCnt_reg <= bitCnt_reg + 6'h1;
         end
      end
   end

   crc3_calc #(.W(FB)) u_rxcrc (
      .frame (rxShift_reg),
      .crc   (rxCrc)
   );

   assign crcOk    = rxCrc == rxShift_reg[2:0]; // R3
   assign shortErr = bitCnt_reg != 6'h0 && bitCnt_reg < 6'h20; // R6
   assign longErr  = bitCnt_reg > 6'h20;
   assign crcErr   = bitCnt_reg == 6'h20 && !crcOk; // R7
   assign exec     = csRise && bitCnt_reg == 6'h20 && crcOk;

   // Reserved bit 23 is not decoded; only the CRC check covers it
   assign rxWrite    = rxShift_reg[spi_frame_pkg::WR_POS]; // R2 R22
   assign rxAddr     = rxShift_reg[spi_frame_pkg::ADDR_LO +: 7]; // R1
   assign rxData     = rxShift_reg[spi_frame_pkg::DATA_LO +: 20]; // R1
   assign isReadOnly = rxAddr == spi_frame_pkg::ADDR_IDENT;
   assign effWrite   = rxWrite && !isReadOnly; // R14

   // Errors gather until the next response carries them out
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         errPend_reg  <= 3'h0;
         lastErr_reg  <= 3'h0;
         frameCnt_reg <= 8'h0;
      end else if (csFall) begin
         errPend_reg <= 3'h0;
      end else if (csRise) begin
         errPend_reg  <= errPend_reg | {shortErr, longErr, crcErr}; // R6 R7
         lastErr_reg  <= {shortErr, longErr, crcErr};
         frameCnt_reg <= frameCnt_reg + 8'h1;
      end
   end

   // Outputs move only once the whole frame is in
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         chanState_reg <= '0;
      end else if (exec && effWrite && rxAddr == spi_frame_pkg::ADDR_SWITCH) begin
         chanState_reg <= rxData[CHAN_COUNT-1:0]; // R15
      end
   end

   // Fault sources set bits in the same cycle a clear lands and win
   always_comb begin
      diag_next = diag_reg;
      if (exec && effWrite && rxAddr == spi_frame_pkg::ADDR_DIAG) begin
         diag_next = 8'h0; // R13
      end
      diag_next = diag_next | diagSet;
      if (|chanFault) begin
         diag_next[spi_frame_pkg::DG_GF] = 1'b1; // R10
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         diag_reg <= 8'h0;
      end else begin
         diag_reg <= diag_next;
      end
   end

   // Read data is latched before any clear so the old value is returned
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         respNext_reg <= 20'h0;
      end else if (csRise) begin
         if (!exec) begin
            respNext_reg <= 20'h0;
         end else begin
            case (rxAddr)
               spi_frame_pkg::ADDR_DIAG:   respNext_reg <= DW'(diag_reg); // R12
               spi_frame_pkg::ADDR_SWITCH: respNext_reg <= DW'(chanState_reg);
               spi_frame_pkg::ADDR_IDENT:  respNext_reg <= IDENT_CODE;
               default:                    respNext_reg <= respData_reg;
            endcase
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         cmdValid_reg <= 1'b0;
         cmdWrite_reg <= 1'b0;
         cmdAddr_reg  <= 7'h0;
         cmdData_reg  <= 20'h0;
         lastCmd_reg  <= 28'h0;
      end else begin
         cmdValid_reg <= exec;
         if (exec) begin
            cmdWrite_reg <= effWrite; // R14
            cmdAddr_reg  <= rxAddr;
            cmdData_reg  <= rxData;
            lastCmd_reg  <= {rxWrite, rxAddr, rxData};
         end
      end
   end

   assign excpBits = {diag_reg[spi_frame_pkg::DG_GF], diag_reg[spi_frame_pkg::DG_GOT],
                      diag_reg[spi_frame_pkg::DG_VDDUV], diag_reg[spi_frame_pkg::DG_VDDOV],
                      diag_reg[spi_frame_pkg::DG_VBUV], diag_reg[spi_frame_pkg::DG_VBOV]}; // R9
   assign respBody = {errPend_reg, excpBits, respNext_reg}; // R5 R8 R11

   crc3_calc #(.W(FB)) u_txcrc (
      .frame ({respBody, 3'h0}),
      .crc   (txCrc)
   );

   // Phase 1 presents the first bit on the first edge, so that edge does not shift
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         txShift_reg    <= 32'h0;
         firstShift_reg <= 1'b0;
      end else if (csFall) begin
         txShift_reg    <= {respBody, txCrc}; // R3 R11
         firstShift_reg <= cpha;
      end else if (shiftEdge) begin
         if (firstShift_reg) begin
            firstShift_reg <= 1'b0;
         end else begin
            txShift_reg <= {txShift_reg[30:0], 1'b0}; // R17
         end
      end
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         misoOe_reg <= 1'b0;
      end else begin
         misoOe_reg <= csActive;
      end
   end

   assign misoOut = txShift_reg[31];
   assign misoOe  = misoOe_reg;

   // Register bus, no wait states
   assign apbWr = psel && penable && pwrite;

   always_comb begin
      hit   = 1'b1;
      rdMux = 32'h0;
      case (paddr)
         spi_frame_pkg::OFS_CTRL:    rdMux = {30'h0, ctrl_reg};
         spi_frame_pkg::OFS_STATUS:  rdMux = {16'h0, frameCnt_reg, 2'h0, errPend_reg, lastErr_reg};
         spi_frame_pkg::OFS_DIAG:    rdMux = {24'h0, diag_reg};
         spi_frame_pkg::OFS_CHAN:    rdMux = 32'(chanState_reg);
         spi_frame_pkg::OFS_RDATA:   rdMux = {12'h0, respData_reg};
         spi_frame_pkg::OFS_LASTCMD: rdMux = {4'h0, lastCmd_reg};
         default:                    hit   = 1'b0;
      endcase
   end

   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_reg     <= spi_frame_pkg::CTRL_RST;
         respData_reg <= 20'h0;
      end else if (apbWr) begin
         if (paddr == spi_frame_pkg::OFS_CTRL) begin
            ctrl_reg <= pwdata[1:0];
         end
         if (paddr == spi_frame_pkg::OFS_RDATA) begin
            respData_reg <= pwdata[19:0];
         end
      end
   end

   // Read data captured in the setup phase
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         prdata_reg <= 32'h0;
      end else if (psel && !penable) begin
         prdata_reg <= rdMux;
      end
   end

   assign prdata    = prdata_reg;
   assign pready    = 1'b1;
   assign pslverr   = psel && penable && !hit;
   assign chanState = chanState_reg;
   assign cmdValid  = cmdValid_reg;
   assign cmdWrite  = cmdWrite_reg;
   assign cmdAddr   = cmdAddr_reg;
   assign cmdData   = cmdData_reg;

   short_flag_a: assert property ( // R6
      @(posedge clock) disable iff (!arst_n)
      csRise && bitCnt_reg == 6'h1f |=> errPend_reg[spi_frame_pkg::ERR_SHORT])
      else $error("short frame not flagged");

   crc_flag_a: assert property ( // R7
      @(posedge clock) disable iff (!arst_n)
      csRise && bitCnt_reg == 6'h20 && !crcOk |=> errPend_reg[0] && !cmdValid_reg)
      else $error("crc error not flagged");

   switch_late_a: assert property ( // R15
      @(posedge clock) disable iff (!arst_n)
      $changed(chanState_reg) |-> $past(csRise) && $past(bitCnt_reg) == 6'h20)
      else $error("channel switched before frame end");

   diag_clear_a: assert property ( // R13
      @(posedge clock) disable iff (!arst_n)
      exec && rxWrite && rxAddr == spi_frame_pkg::ADDR_DIAG && diagSet == 8'h0
      && chanFault == '0 |=> diag_reg == 8'h0)
      else $error("diagnostic register not cleared");

   read_only_a: assert property ( // R14
      @(posedge clock) disable iff (!arst_n)
      cmdValid_reg && cmdAddr_reg == spi_frame_pkg::ADDR_IDENT |-> !cmdWrite_reg)
      else $error("write taken on read-only address");

   excp_map_a: assert property ( // R8 R9
      @(posedge clock) disable iff (!arst_n)
      csFall |=> txShift_reg[28:23] == {$past(diag_reg[6]), $past(diag_reg[4]),
                                       $past(diag_reg[3:0])})
      else $error("exception bits misplaced");

   err_top_a: assert property ( // R5
      @(posedge clock) disable iff (!arst_n)
      csFall |=> txShift_reg[31:29] == $past(errPend_reg) ##1 errPend_reg == 3'h0)
      else $error("error flags not sent");

   cmd_pulse_a: assert property ( // R2
      @(posedge clock) disable iff (!arst_n)
      exec |=> cmdValid_reg && cmdWrite_reg == $past(effWrite) ##1 !cmdValid_reg)
      else $error("command pulse wrong");

   apb_err_a: assert property (
      @(posedge clock) disable iff (!arst_n)
      psel && penable && paddr == 8'h18 |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
endmodule : driver_spi_frame_interface

// File: shared/spi_frame_pkg.sv
// Constants for the solenoid driver frame interface
// What this block does
// (R1) Command frame is 32 bits: write flag, 7-bit address, 20-bit data
// (R2) Write flag 1 means write, 0 means read
// (R3) Both frame kinds end in a 3-bit CRC, generator x3+x2+x+1 (1111)
// (R4) CRC is XOR division of the frame by the generator, shifting right
// (R5) Response bits 31 to 29 carry the three link error flags
// (R6) Short-frame flag, top error bit, set when fewer than 32 bits clocked; a frame with no bits clocked leaves it clear
// (R7) CRC error flag, lowest error bit, set when command CRC check fails
// (R8) Six channel exception bits below the error flags, from diagnostic register
// (R9) Exception bits mirror diagnostic bits 6, 4, 3, 2, 1, 0 from the top down
// (R10) Top two exception bits report faults on any of the 12 channels; chanFault sets only the top bit, DG_GF
// (R11) Response carries 20-bit data and 3-bit CRC where the command has them
// (R12) No address in responses; read data comes in the next frame
// (R13) Write flag on a diagnostic status address clears that register
// (R14) Read-only registers take the flag as 0; accesses act as reads
// (R15) Channel switch takes effect only after all 32 bits arrive
// (R16) Master drops chip select, then clocks one command bit per clock
// (R17) Full duplex: one bit in and one bit out per clock
// (R18) Clock polarity 0 idles low, 1 idles high
// (R19) Phase 0 samples on first edge; phase 1 samples on second edge
// (R20) Pulse train: switch, pause, complementary switch, diagnostic, repeat
// (R21) For duty above half the master swaps the two switch frames
// (R22) Reserved command bit is sent as 0 and ignored
package spi_frame_pkg;
   localparam int         FRAME_BITS = 32;
   localparam int         ADDR_W     = 7;
   localparam int         DATA_W     = 20;
   localparam int         CRC_W      = 3;
   localparam int         EXCP_W     = 6;
   localparam int         WR_POS     = 31;
   localparam int         ADDR_LO    = 24;
   localparam int         DATA_LO    = 3;
   localparam logic [3:0] CRC_POLY   = 4'hf;
   localparam int         ERR_SHORT  = 2;
   localparam int         ERR_LONG   = 1;
   localparam int         ERR_CRC    = 0;
   localparam int         DG_GF      = 6;
   localparam int         DG_GOT     = 4;
   localparam int         DG_VDDUV   = 3;
   localparam int         DG_VDDOV   = 2;
   localparam int         DG_VBUV    = 1;
   localparam int         DG_VBOV    = 0;
   localparam logic [6:0] ADDR_SWITCH = 7'h10;
   localparam logic [6:0] ADDR_DIAG   = 7'h20;
   localparam logic [6:0] ADDR_IDENT  = 7'h7f;
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_DIAG   = 8'h08;
   localparam logic [7:0] OFS_CHAN   = 8'h0c;
   localparam logic [7:0] OFS_RDATA  = 8'h10;
   localparam logic [7:0] OFS_LASTCMD = 8'h14;
   localparam int         CTRL_CPOL  = 0;
   localparam int         CTRL_CPHA  = 1;
   localparam logic [1:0] CTRL_RST   = 2'h0;
endpackage : spi_frame_pkg

// File: shared/link_sync_if.sv
// Raw and synchronised serial link pins
`timescale 1ns/10ps
interface link_sync_if;
   logic sclkRaw;
   logic csNRaw;
   logic mosiRaw;
   logic sclkS;
   logic csNS;
   logic mosiS;
   modport sync (input sclkRaw, csNRaw, mosiRaw, output sclkS, csNS, mosiS);
   modport core (output sclkRaw, csNRaw, mosiRaw, input sclkS, csNS, mosiS);
endinterface : link_sync_if

// File: core/link_sync.sv
// Two-stage synchroniser for the serial link pins
`timescale 1ns/10ps
module link_sync (
   input wire logic clock,
   input wire logic arst_n,
   link_sync_if.sync lnk
);
   logic [2:0] stage1_reg;
   logic [2:0] stage2_reg;

   // Chip select resets high so no frame is seen at start
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         stage1_reg <= 3'h2;
         stage2_reg <= 3'h2;
      end else begin
         stage1_reg <= {lnk.sclkRaw, lnk.csNRaw, lnk.mosiRaw};
         stage2_reg <= stage1_reg;
      end
   end

   assign lnk.sclkS = stage2_reg[2];
   assign lnk.csNS  = stage2_reg[1];
   assign lnk.mosiS = stage2_reg[0];
endmodule : link_sync

// File: core/crc3_calc.sv
// Three-bit frame CRC by right-shifting XOR division
`timescale 1ns/10ps
module crc3_calc #(
   parameter int W = 32
) (
   input  wire logic [W-1:0] frame,
   output logic      [2:0]   crc
);
   // Low three bits are the CRC slot and take no part
   always_comb begin
      logic fb;
      fb  = 1'b0;
      crc = 3'h0;
      for (int i = W - 1; i >= 3; i--) begin
         fb  = frame[i] ^ crc[2];
         crc = {crc[1:0], 1'b0} ^ (fb ? spi_frame_pkg::CRC_POLY[2:0] : 3'h0); // R4
      end
   end
endmodule : crc3_calc

// File: test/spi_master_model.sv
// Behavioural SPI master that drives the frame link
`timescale 1ns/10ps
module spi_master_model (
   output logic      sclk,
   output logic      csN,
   output logic      mosi,
   input  wire logic miso,
   input  wire logic cpol,
   input  wire logic cpha
);
   initial begin
      sclk = 1'b0;
      csN  = 1'b1;
      mosi = 1'b0;
   end

   // A count below 32 sends a truncated frame
   task automatic frame(input logic [31:0] c, input int n, output logic [31:0] r);
      r = 32'h0;
      sclk = cpol;
      #80 csN = 1'b0;
      #80;
      for (int i = 0; i < n; i++) begin
         if (!cpha) mosi = c[31-i];
         #40 sclk = ~cpol;
         if (!cpha) r[31-i] = miso;
         else mosi = c[31-i];
         #40 sclk = cpol;
         if (cpha) r[31-i] = miso;
      end
      #80 csN = 1'b1;
      // Released line must not keep showing the last bit
      mosi = ~mosi;
      #200;
   endtask : frame
endmodule : spi_master_model

// File: test/driver_spi_frame_interface_tb.sv
// Self-checking bench for the frame link slave
`timescale 1ns/10ps
module driver_spi_frame_interface_tb;
   logic        clock;
   logic        arst_n;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        sclk;
   logic        csN;
   logic        mosi;
   logic        misoOut;
   logic        misoOe;
   logic        misoLast;
   logic        misoWire;
   logic [7:0]  diagSet;
   logic [11:0] chanFault;
   logic [11:0] chanState;
   logic        cmdValid;
   logic        cmdWrite;
   logic [6:0]  cmdAddr;
   logic [19:0] cmdData;
   logic        cpol;
   logic        cpha;
   int          miscompares = 0;
   int          checked = 0;
   int          cmdCount = 0;

   // Arbitrary value
   localparam logic [19:0] IDENT = 20'h0a5c3;

   driver_spi_frame_interface #(.IDENT_CODE(IDENT)) DUT (.clock, .arst_n, .psel, .penable,
      .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .sclk, .csN, .mosi, .misoOut, .misoOe,
      .diagSet, .chanFault, .chanState, .cmdValid, .cmdWrite, .cmdAddr, .cmdData);
   spi_master_model master (.sclk, .csN, .mosi, .miso(misoWire), .cpol, .cpha);

   // Undriven line shows the inverse of its last value
   assign misoWire = misoOe ? misoOut : ~misoLast;
   always @(posedge clock) begin
      if (misoOe) misoLast <= misoOut;
      if (cmdValid === 1'b1) cmdCount <= cmdCount + 1;
   end

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   function automatic logic [2:0] crc3(input logic [31:0] d);
      logic [2:0] r;
      logic       fb;
      r = 3'h0;
      for (int i = 31; i >= 3; i--) begin
         fb = d[i] ^ r[2];
         r  = {r[1:0], 1'b0} ^ {3{fb}};
      end
      return r;
   endfunction : crc3

   function automatic logic [31:0] mk(input logic w, input logic [6:0] a, input logic [19:0] d);
      logic [31:0] f;
      f = {w, a, 1'b0, d, 3'h0};
      return {f[31:3], crc3(f)};
   endfunction : mk

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      @(posedge clock);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic xfer(input logic [31:0] c, input int n, output logic [31:0] r);
      // Pins move on the falling edge, clear of sampling and of pending mode updates
      @(negedge clock);
      master.frame(c, n, r);
      if (n == 32) chk("resp crc", {29'h0, r[2:0]}, {29'h0, crc3(r)});
      chk("miso released", {31'h0, misoOe}, 32'h0);
   endtask : xfer

   task automatic t_regs;
      logic [31:0] r;
      logic        e;
      apb(1'b0, spi_frame_pkg::OFS_CTRL, 32'h0, r, e);
      chk("ctrl reset", r, 32'h0);
      apb(1'b1, spi_frame_pkg::OFS_CHAN, 32'hfff, r, e);
      apb(1'b0, spi_frame_pkg::OFS_CHAN, 32'h0, r, e);
      chk("chan ro", r, 32'h0);
      apb(1'b0, 8'h18, 32'h0, r, e);
      chk("unmapped err", {31'h0, e}, 32'h1);
      chk("unmapped data", r, 32'h0);
      apb(1'b1, spi_frame_pkg::OFS_RDATA, 32'h12345, r, e);
      apb(1'b0, spi_frame_pkg::OFS_RDATA, 32'h0, r, e);
      chk("rdata rw", r, 32'h12345);
      xfer(mk(1'b0, 7'h01, 20'h0), 32, r);
      xfer(mk(1'b0, 7'h01, 20'h0), 32, r);
      chk("rdata link", {12'h0, r[22:3]}, 32'h12345);
      apb(1'b0, spi_frame_pkg::OFS_STATUS, 32'h0, r, e);
      chk("status", r, 32'h200);
      chk("ready", {31'h0, pready}, 32'h1);
      $display("Done registers");
   endtask : t_regs

   task automatic t_modes;
      logic [31:0] r;
      logic        e;
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, spi_frame_pkg::OFS_CTRL, m, r, e);
         apb(1'b0, spi_frame_pkg::OFS_CTRL, 32'h0, r, e);
         chk("ctrl rw", r, m);
         cpol <= m[0];
         cpha <= m[1];
         xfer(mk(1'b1, spi_frame_pkg::ADDR_IDENT, 20'h12345), 32, r);
         chk("ro flag", {31'h0, cmdWrite}, 32'h0);
         xfer(mk(1'b0, spi_frame_pkg::ADDR_IDENT, 20'h0), 32, r);
         chk("link errs", {29'h0, r[31:29]}, 32'h0);
         chk("ident", {12'h0, r[22:3]}, {12'h0, IDENT});
      end
      apb(1'b1, spi_frame_pkg::OFS_CTRL, 32'h0, r, e);
      cpol <= 1'b0;
      cpha <= 1'b0;
      $display("Done modes");
   endtask : t_modes

   task automatic t_pulse;
      logic [31:0] r;
      logic [31:0] f;
      logic [19:0] a;
      logic [19:0] b;
      int          n0;
      for (int k = 0; k < 2; k++) begin
         a  = k ? 20'h00a5a : 20'h005a5;
         b  = k ? 20'h005a5 : 20'h00a5a;
         n0 = cmdCount;
         f  = mk(1'b1, spi_frame_pkg::ADDR_SWITCH, a) | 32'h0080_0000;
         xfer({f[31:3], crc3(f)}, 32, r);
         chk("switch a", {20'h0, chanState}, {20'h0, a[11:0]});
         #500;
         xfer(mk(1'b1, spi_frame_pkg::ADDR_SWITCH, b), 32, r);
         chk("switch b", {20'h0, chanState}, {20'h0, b[11:0]});
         chk("switch cmd", {12'h0, cmdData}, {12'h0, b});
         xfer(mk(1'b0, spi_frame_pkg::ADDR_DIAG, 20'h0), 32, r);
         chk("switch data", {12'h0, r[22:3]}, {20'h0, a[11:0]});
         chk("diag addr", {25'h0, cmdAddr}, {25'h0, spi_frame_pkg::ADDR_DIAG});
         chk("commands", 32'(cmdCount - n0), 32'h3);
      end
      $display("Done pulse train");
   endtask : t_pulse

   task automatic t_errors;
      logic [31:0] r;
      logic [11:0] s;
      int          n0;
      s  = chanState;
      n0 = cmdCount;
      xfer(mk(1'b1, spi_frame_pkg::ADDR_SWITCH, 20'hfff), 31, r);
      chk("short no switch", {20'h0, chanState}, {20'h0, s});
      xfer(mk(1'b1, spi_frame_pkg::ADDR_SWITCH, 20'hfff) ^ 32'h1, 32, r);
      chk("short flag", {29'h0, r[31:29]}, 32'h4);
      chk("crc no switch", {20'h0, chanState}, {20'h0, s});
      xfer(mk(1'b0, spi_frame_pkg::ADDR_IDENT, 20'h0), 32, r);
      chk("crc flag", {29'h0, r[31:29]}, 32'h1);
      xfer(mk(1'b0, spi_frame_pkg::ADDR_IDENT, 20'h0), 32, r);
      chk("flags clear", {29'h0, r[31:29]}, 32'h0);
      chk("bad frames", 32'(cmdCount - n0), 32'h2);
      $display("Done errors");
   endtask : t_errors

   task automatic t_diag;
      logic [31:0] r;
      logic        e;
      @(posedge clock);
      diagSet   <= 8'h1c;
      chanFault <= 12'h800;
      @(posedge clock);
      diagSet   <= 8'h0;
      chanFault <= 12'h0;
      apb(1'b0, spi_frame_pkg::OFS_DIAG, 32'h0, r, e);
      chk("diag set", r, 32'h5c);
      xfer(mk(1'b0, spi_frame_pkg::ADDR_DIAG, 20'h0), 32, r);
      xfer(mk(1'b1, spi_frame_pkg::ADDR_DIAG, 20'h0), 32, r);
      chk("exceptions", {26'h0, r[28:23]}, 32'h3c);
      chk("diag data", {12'h0, r[22:3]}, 32'h5c);
      apb(1'b0, spi_frame_pkg::OFS_DIAG, 32'h0, r, e);
      chk("diag clear", r, 32'h0);
      xfer(mk(1'b0, spi_frame_pkg::ADDR_IDENT, 20'h0), 32, r);
      chk("exceptions clear", {26'h0, r[28:23]}, 32'h0);
      $display("Done diagnostics");
   endtask : t_diag

   task automatic tally_and_finish;
      $display("Checks %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : tally_and_finish

   // Whole run needs about 70 us
   initial begin
      #400000;
      miscompares++;
      tally_and_finish();
   end

   initial begin
      arst_n    = 1'b0;
      psel      = 1'b0;
      penable   = 1'b0;
      pwrite    = 1'b0;
      paddr     = 8'h0;
      pwdata    = 32'h0;
      diagSet   = 8'h0;
      chanFault = 12'h0;
      cpol      = 1'b0;
      cpha      = 1'b0;
      misoLast  = 1'b0;
      repeat (3) @(posedge clock);
      arst_n <= 1'b1;
      repeat (3) @(posedge clock);
      t_regs();
      t_modes();
      t_pulse();
      t_errors();
      t_diag();
      tally_and_finish();
   end
endmodule : driver_spi_frame_interface_tb
